// >>> inc/pin_select_pkg.sv
// Function
// - Second port is 32 bits, per-bit direction.
// - Only bits 16 to 31 are real pins.
// - Each pin follows its selected function.
// - Trace strap low in reset enables trace.
// - Debug strap low in reset enables debug.
// - Trace drives packet, sync, pipeline state, clock.
// - Bit 25 is external trigger input in trace.
// - Debug pins carry JTAG plus returned test clock.
// - Test clock below one sixth cpu clock.
// - Reset holds ports in default state.
// - After reset, fetching starts at address zero.
package pin_select_pkg;
    localparam int PORT_WIDTH = 32;
    localparam int PIN_LO = 16;
    localparam int PIN_HI = 31;
    localparam int TRACE_LO = 16;
    localparam int TRACE_HI = 25;
    localparam int DEBUG_LO = 26;
    localparam int DEBUG_HI = 31;
    localparam int TRACE_PKT_LSB = 16;
    localparam int TRACE_PKT_WIDTH = 4;
    localparam int TRACE_SYNC_BIT = 20;
    localparam int PIPE_STATE_LSB = 21;
    localparam int PIPE_STATE_WIDTH = 3;
    localparam int TRACE_CLK_BIT = 24;
    localparam int EXT_TRIG_BIT = 25;
    localparam int RETURNED_TEST_CLOCK_BIT = 26;
    localparam int TDO_BIT = 27;
    localparam int TDI_BIT = 28;
    localparam int TCK_BIT = 29;
    localparam int TMS_BIT = 30;
    localparam int TRST_BIT = 31;
    localparam int TCK_CLOCK_RATIO = 6;
    localparam logic [31:0] RESET_FETCH_ADDR = 32'h0000_0000;
    localparam logic PIN_OUT_RESET = 1'b0;
    localparam logic PIN_OE_RESET = 1'b0;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic TDI_IDLE = 1'b1;
    localparam logic TMS_IDLE = 1'b1;
    localparam logic TCK_IDLE = 1'b0;

    typedef enum logic [2:0] {
        PIN_GPIO = 3'b001,
        PIN_ALT_OUT = 3'b010,
        PIN_ALT_IN = 3'b100
    } pin_func_e;
endpackage

// >>> logic/strap_latch.sv
`timescale 1ns/1ps
module strap_latch (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // Strap pin levels.
    input wire logic i_trace_strap_pin,
    input wire logic i_debug_strap_pin,
    // Latched enables.
    output logic o_trace_en,
    output logic o_debug_en,
    output logic o_release
);
    import pin_select_pkg::*;

    logic trace_sample, debug_sample, in_reset;
    logic next_trace_sample, next_debug_sample, next_in_reset;
    logic next_trace_en, next_debug_en, next_release;

    always_comb begin
        next_trace_sample = trace_sample;
        next_debug_sample = debug_sample;
        next_in_reset = 1'b0;
        next_trace_en = o_trace_en;
        next_debug_en = o_debug_en;
        next_release = 1'b0;
        if (i_reset) begin
            next_trace_sample = i_trace_strap_pin;
            next_debug_sample = i_debug_strap_pin;
            next_in_reset = 1'b1;
            next_trace_en = ENABLE_RESET;
            next_debug_en = ENABLE_RESET;
        end else if (in_reset) begin
            next_trace_en = ~trace_sample;
            next_debug_en = ~debug_sample;
            next_release = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        trace_sample <= next_trace_sample;
        debug_sample <= next_debug_sample;
        in_reset <= next_in_reset;
        o_trace_en <= next_trace_en;
        o_debug_en <= next_debug_en;
        o_release <= next_release;
    end
endmodule // strap_latch

// >>> logic/port_bit_cell.sv
`timescale 1ns/1ps
module port_bit_cell (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // Function and sources.
    input wire pin_select_pkg::pin_func_e i_func,
    input wire logic i_gpio_out,
    input wire logic i_gpio_dir,
    input wire logic i_alt_out,
    // Pin.
    input wire logic i_pin_in,
    output logic o_pin_out,
    output logic o_pin_oe,
    // Sampled pin level.
    output logic o_gpio_in,
    output logic o_alt_in
);
    import pin_select_pkg::*;

    logic next_pin_out, next_pin_oe, next_gpio_in, next_alt_in;

    always_comb begin
        next_pin_out = PIN_OUT_RESET;
        next_pin_oe = PIN_OE_RESET;
        next_gpio_in = i_pin_in;
        next_alt_in = 1'b0;
        if (i_reset) begin
            next_gpio_in = 1'b0;
        end else begin
            unique case (i_func)
                PIN_GPIO: begin
                    next_pin_out = i_gpio_out;
                    next_pin_oe = i_gpio_dir;
                end
                PIN_ALT_OUT: begin
                    next_pin_out = i_alt_out;
                    next_pin_oe = 1'b1;
                end
                PIN_ALT_IN: begin
                    next_alt_in = i_pin_in;
                end
                default: begin
                    next_pin_oe = PIN_OE_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        o_pin_out <= next_pin_out;
        o_pin_oe <= next_pin_oe;
        o_gpio_in <= next_gpio_in;
        o_alt_in <= next_alt_in;
    end
endmodule // port_bit_cell

// >>> logic/port1_debug_trace_pin_select.sv
`timescale 1ns/1ps
module port1_debug_trace_pin_select (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // Pins of the second port, bits 16 to 31.
    input wire logic [pin_select_pkg::PIN_HI:pin_select_pkg::PIN_LO] i_pin_in,
    output logic [pin_select_pkg::PIN_HI:pin_select_pkg::PIN_LO] o_pin_out,
    output logic [pin_select_pkg::PIN_HI:pin_select_pkg::PIN_LO] o_pin_oe,
    // General-purpose port, software side.
    input wire logic [pin_select_pkg::PORT_WIDTH-1:0] i_gpio_out,
    input wire logic [pin_select_pkg::PORT_WIDTH-1:0] i_gpio_dir,
    output logic [pin_select_pkg::PORT_WIDTH-1:0] o_gpio_in,
    // Trace sources from the core.
    input wire logic [pin_select_pkg::TRACE_PKT_WIDTH-1:0] i_trace_packet,
    input wire logic i_trace_sync,
    input wire logic [pin_select_pkg::PIPE_STATE_WIDTH-1:0] i_pipe_state,
    input wire logic i_trace_out_clock,
    output logic o_external_trigger_in,
    // Debug port toward the core.
    input wire logic i_tdo,
    output logic o_tdi,
    output logic o_tck,
    output logic o_tms,
    output logic o_trst_n,
    // Mode and processor start.
    output logic o_trace_en,
    output logic o_debug_en,
    output logic o_cpu_start,
    output logic [31:0] o_fetch_addr
);
    import pin_select_pkg::*;

    logic trace_en, debug_en, release_pulse;
    logic [PIN_HI:PIN_LO] alt_out;
    logic [PIN_HI:PIN_LO] alt_in;
    logic [PIN_HI:PIN_LO] gpio_in_hi;
    pin_func_e pin_func [PIN_HI:PIN_LO];

    strap_latch u_strap (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_trace_strap_pin(i_pin_in[TRACE_SYNC_BIT]),
        .i_debug_strap_pin(i_pin_in[RETURNED_TEST_CLOCK_BIT]),
        .o_trace_en(trace_en),
        .o_debug_en(debug_en),
        .o_release(release_pulse)
    );

    // Function of each pin from the latched enables.
    always_comb begin
        for (int b = PIN_LO; b <= PIN_HI; b++) begin
            pin_func[b] = PIN_GPIO;
            if (trace_en && b >= TRACE_LO && b <= TRACE_HI) begin
                pin_func[b] = (b == EXT_TRIG_BIT) ? PIN_ALT_IN : PIN_ALT_OUT;
            end
            if (debug_en && b >= DEBUG_LO && b <= DEBUG_HI) begin
                if (b == TDO_BIT || b == RETURNED_TEST_CLOCK_BIT) begin
                    pin_func[b] = PIN_ALT_OUT;
                end else begin
                    pin_func[b] = PIN_ALT_IN;
                end
            end
        end
    end

    // Returned test clock: the test clock as seen in the cpu clock domain.
    logic tck_return, next_tck_return;

    always_comb begin
        next_tck_return = alt_in[TCK_BIT];
        if (i_reset) begin
            next_tck_return = TCK_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        tck_return <= next_tck_return;
    end

    // Alternate outputs of each pin.
    always_comb begin
        alt_out = '0;
        alt_out[TRACE_PKT_LSB +: TRACE_PKT_WIDTH] = i_trace_packet;
        alt_out[TRACE_SYNC_BIT] = i_trace_sync;
        alt_out[PIPE_STATE_LSB +: PIPE_STATE_WIDTH] = i_pipe_state;
        alt_out[TRACE_CLK_BIT] = i_trace_out_clock;
        alt_out[RETURNED_TEST_CLOCK_BIT] = tck_return;
        alt_out[TDO_BIT] = i_tdo;
    end

    genvar g;
    generate
        for (g = PIN_LO; g <= PIN_HI; g++) begin : g_pin
            port_bit_cell u_cell (
                .i_clk(i_clk),
                .i_reset(i_reset),
                .i_func(pin_func[g]),
                .i_gpio_out(i_gpio_out[g]),
                .i_gpio_dir(i_gpio_dir[g]),
                .i_alt_out(alt_out[g]),
                .i_pin_in(i_pin_in[g]),
                .o_pin_out(o_pin_out[g]),
                .o_pin_oe(o_pin_oe[g]),
                .o_gpio_in(gpio_in_hi[g]),
                .o_alt_in(alt_in[g])
            );
        end
    endgenerate

    // Only the upper half is real; the lower half reads as zero.
    assign o_gpio_in = {gpio_in_hi, {PIN_LO{1'b0}}};

    // Debug inputs toward the core, parked while debug is off.
    always_comb begin
        o_tdi = TDI_IDLE;
        o_tms = TMS_IDLE;
        o_tck = TCK_IDLE;
        o_trst_n = 1'b0;
        if (debug_en) begin
            o_tdi = alt_in[TDI_BIT];
            o_tms = alt_in[TMS_BIT];
            o_tck = alt_in[TCK_BIT];
            o_trst_n = alt_in[TRST_BIT];
        end
    end

    assign o_external_trigger_in = alt_in[EXT_TRIG_BIT];
    assign o_trace_en = trace_en;
    assign o_debug_en = debug_en;

    // Processor start after reset release.
    logic cpu_start, next_cpu_start;
    logic [31:0] fetch_addr, next_fetch_addr;

    always_comb begin
        next_cpu_start = release_pulse;
        next_fetch_addr = fetch_addr;
        if (i_reset) begin
            next_cpu_start = 1'b0;
            next_fetch_addr = RESET_FETCH_ADDR;
        end
    end

    always_ff @(posedge i_clk) begin
        cpu_start <= next_cpu_start;
        fetch_addr <= next_fetch_addr;
    end

    assign o_cpu_start = cpu_start;
    assign o_fetch_addr = fetch_addr;

    // Checks.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence trace_strap_low_s;
        i_reset && !i_pin_in[TRACE_SYNC_BIT] ##1 !i_reset;
    endsequence

    sequence debug_strap_low_s;
        i_reset && !i_pin_in[RETURNED_TEST_CLOCK_BIT] ##1 !i_reset;
    endsequence

    sequence release_s;
        i_reset ##1 !i_reset;
    endsequence

    sequence trace_held_s;
        trace_en && $past(trace_en);
    endsequence

    sequence debug_held_s;
        debug_en && $past(debug_en);
    endsequence

    property trace_strap_p;
        @(posedge i_clk) disable iff (1'b0)
        trace_strap_low_s |=> trace_en;
    endproperty

    property debug_strap_p;
        @(posedge i_clk) disable iff (1'b0)
        debug_strap_low_s |=> debug_en;
    endproperty

    trace_strap_sets_a: assert property (trace_strap_p)
        else $error("Trace strap low did not enable trace.");

    debug_strap_sets_a: assert property (debug_strap_p)
        else $error("Debug strap low did not enable debug.");

    strap_high_clear_a: assert property (
        @(posedge i_clk) disable iff (1'b0)
        (i_reset && i_pin_in[TRACE_SYNC_BIT] && i_pin_in[RETURNED_TEST_CLOCK_BIT]) ##1 !i_reset
        |=> !trace_en && !debug_en)
        else $error("Straps high yet a debug function was enabled.");

    strap_hold_a: assert property (
        !$past(i_reset) && !$past(i_reset, 2) |-> $stable(trace_en) && $stable(debug_en))
        else $error("Strap enables changed outside reset.");

    reset_quiet_a: assert property (
        @(posedge i_clk) disable iff (1'b0)
        i_reset |=> o_pin_oe == '0 && o_gpio_in == '0 && !trace_en && !debug_en)
        else $error("Port not in default state after a reset cycle.");

    cpu_start_a: assert property (
        @(posedge i_clk) disable iff (1'b0)
        release_s |=> ##1 cpu_start && fetch_addr == RESET_FETCH_ADDR)
        else $error("Processor start missing or not at address zero.");

    low_bits_a: assert property (
        o_gpio_in[PIN_LO-1:0] == '0)
        else $error("Unimplemented port bits read nonzero.");

    trace_drive_a: assert property (
        trace_en && $past(trace_en) |->
        (&o_pin_oe[TRACE_CLK_BIT:TRACE_LO]) && !o_pin_oe[EXT_TRIG_BIT]
        && o_pin_out[TRACE_SYNC_BIT] == $past(i_trace_sync)
        && o_pin_out[TRACE_CLK_BIT] == $past(i_trace_out_clock))
        else $error("Trace pins not driven as selected.");

    trigger_in_a: assert property (
        trace_en && $past(trace_en) |->
        o_external_trigger_in == $past(i_pin_in[EXT_TRIG_BIT]))
        else $error("External trigger did not follow its pin.");

    debug_drive_a: assert property (
        debug_en && $past(debug_en) |->
        o_pin_oe[DEBUG_HI:DEBUG_LO] == 6'h03
        && o_pin_out[TDO_BIT] == $past(i_tdo))
        else $error("Debug pin directions or test data out wrong.");

    returned_test_clock_follow_a: assert property (
        debug_en && $past(debug_en, 3) |->
        o_pin_out[RETURNED_TEST_CLOCK_BIT] == $past(i_pin_in[TCK_BIT], 3))
        else $error("Returned test clock does not follow test clock.");

    gpio_dir_a: assert property (
        !$past(i_reset) && !trace_en && !debug_en && $past(!trace_en && !debug_en) |->
        o_pin_oe == $past(i_gpio_dir[PIN_HI:PIN_LO])
        && o_pin_out == $past(i_gpio_out[PIN_HI:PIN_LO]))
        else $error("General-purpose pin direction or level wrong.");

    trace_data_a: assert property (
        trace_held_s |->
        o_pin_out[TRACE_PKT_LSB +: TRACE_PKT_WIDTH] == $past(i_trace_packet)
        && o_pin_out[PIPE_STATE_LSB +: PIPE_STATE_WIDTH] == $past(i_pipe_state))
        else $error("Trace packet or pipeline state not on its pins.");

    trigger_off_a: assert property (
        !trace_en |-> !o_external_trigger_in)
        else $error("External trigger seen while trace is off.");

    debug_in_a: assert property (
        debug_held_s |->
        o_tdi == $past(i_pin_in[TDI_BIT]) && o_tms == $past(i_pin_in[TMS_BIT])
        && o_tck == $past(i_pin_in[TCK_BIT]) && o_trst_n == $past(i_pin_in[TRST_BIT]))
        else $error("Debug inputs toward the core do not follow their pins.");

    debug_park_a: assert property (
        !debug_en |->
        o_tdi == TDI_IDLE && o_tms == TMS_IDLE && o_tck == TCK_IDLE && !o_trst_n)
        else $error("Debug inputs toward the core not parked.");

    gpio_in_follow_a: assert property (
        !$past(i_reset) |-> o_gpio_in[PIN_HI:PIN_LO] == $past(i_pin_in))
        else $error("General-purpose input does not follow its pins.");

    trace_pins_gpio_a: assert property (
        debug_en && !trace_en && $past(debug_en && !trace_en) |->
        o_pin_oe[TRACE_HI:TRACE_LO] == $past(i_gpio_dir[TRACE_HI:TRACE_LO])
        && o_pin_out[TRACE_HI:TRACE_LO] == $past(i_gpio_out[TRACE_HI:TRACE_LO]))
        else $error("Trace range pins not under software control.");

    debug_pins_gpio_a: assert property (
        trace_en && !debug_en && $past(trace_en && !debug_en) |->
        o_pin_oe[DEBUG_HI:DEBUG_LO] == $past(i_gpio_dir[DEBUG_HI:DEBUG_LO])
        && o_pin_out[DEBUG_HI:DEBUG_LO] == $past(i_gpio_out[DEBUG_HI:DEBUG_LO]))
        else $error("Debug range pins not under software control.");

    start_pulse_a: assert property (
        cpu_start |=> !cpu_start)
        else $error("Processor start lasted more than one cycle.");

    start_after_release_a: assert property (
        cpu_start |-> !$past(i_reset) && !$past(i_reset, 2) && $past(i_reset, 3))
        else $error("Processor start without a reset release.");

    fetch_hold_a: assert property (
        !$past(i_reset) |-> $stable(fetch_addr))
        else $error("Fetch address changed outside reset.");

    enable_rise_a: assert property (
        $rose(trace_en) || $rose(debug_en) |-> !$past(i_reset) && $past(i_reset, 2))
        else $error("Strap enable rose away from a reset release.");

    tck_idle_a: assert property (
        @(posedge i_clk) disable iff (1'b0)
        i_reset |=> tck_return == TCK_IDLE)
        else $error("Returned test clock not idle after a reset cycle.");

    reset_out_a: assert property (
        @(posedge i_clk) disable iff (1'b0)
        i_reset |=> o_pin_out == '0 && !o_cpu_start && o_fetch_addr == RESET_FETCH_ADDR)
        else $error("Pin levels or processor start not at reset values.");
endmodule // port1_debug_trace_pin_select

// >>> dv/debug_probe_model.sv
`timescale 1ns/1ps
module debug_probe_model (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // Requested modes and levels.
    input wire logic i_want_trace,
    input wire logic i_want_debug,
    input wire logic [2:0] i_jtag,
    input wire logic i_trig,
    // Probe drive on pins 16 to 31.
    output logic [31:16] o_drv,
    output logic [31:16] o_oe
);
    logic [1:0] div = 2'h0;
    logic tck = 1'b0;
    // Test clock toggles every four cpu clocks, period eight.
    always @(negedge i_clk) begin
        div <= div + 2'h1;
        if (div == 2'h3) begin
            tck <= ~tck;
        end
    end
    always_comb begin
        o_drv = 16'h0000;
        o_oe = 16'h0000;
        // Straps are pulled low only while reset is held.
        o_oe[20] = i_reset & i_want_trace;
        o_oe[26] = i_reset & i_want_debug;
        // Trigger driven into the trace logic.
        o_oe[25] = ~i_reset & i_want_trace;
        o_drv[25] = i_trig;
        // Trst, tms, tck and tdi.
        o_oe[31:28] = {4{~i_reset & i_want_debug}};
        o_drv[31:28] = {i_jtag[2:1], tck, i_jtag[0]};
    end
endmodule // debug_probe_model

// >>> dv/port1_debug_trace_pin_select_tb.sv
`timescale 1ns/1ps
module port1_debug_trace_pin_select_tb;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [31:16] i_pin_in, o_pin_out, o_pin_oe, m_drv, m_oe;
    logic [31:16] t_oe = 16'h0;
    logic [31:16] t_val = 16'h0;
    logic [31:0] i_gpio_out = 32'h0;
    logic [31:0] i_gpio_dir = 32'h0;
    logic [31:0] o_gpio_in, o_fetch_addr;
    logic [3:0] i_trace_packet = 4'h0;
    logic [2:0] i_pipe_state = 3'h0;
    logic [2:0] jtag = 3'h0;
    logic [2:0] s = 3'h0;
    logic i_trace_sync = 1'b0;
    logic i_trace_out_clock = 1'b0;
    logic i_tdo = 1'b0;
    logic want_t = 1'b0;
    logic want_d = 1'b0;
    logic trig = 1'b0;
    logic o_external_trigger_in, o_tdi, o_tck, o_tms, o_trst_n, o_trace_en, o_debug_en, o_cpu_start;
    int error_cnt = 0;
    int checks_done = 0;
    always #12.5 i_clk = ~i_clk;
    // Pins carry a pull-up when nobody drives them.
    assign i_pin_in = (o_pin_oe & o_pin_out) | (~o_pin_oe & m_oe & m_drv)
        | (~o_pin_oe & ~m_oe & ((t_oe & t_val) | ~t_oe));
    always @(posedge i_clk) s <= {s[1:0], i_pin_in[29]};
    port1_debug_trace_pin_select port1_debug_trace_pin_select_i (.i_clk(i_clk), .i_reset(i_reset),
        .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .i_gpio_out(i_gpio_out),
        .i_gpio_dir(i_gpio_dir), .o_gpio_in(o_gpio_in), .i_trace_packet(i_trace_packet),
        .i_trace_sync(i_trace_sync), .i_pipe_state(i_pipe_state), .i_trace_out_clock(i_trace_out_clock),
        .o_external_trigger_in(o_external_trigger_in), .i_tdo(i_tdo), .o_tdi(o_tdi), .o_tck(o_tck),
        .o_tms(o_tms), .o_trst_n(o_trst_n), .o_trace_en(o_trace_en), .o_debug_en(o_debug_en),
        .o_cpu_start(o_cpu_start), .o_fetch_addr(o_fetch_addr));
    debug_probe_model debug_probe_model_i (.i_clk(i_clk), .i_reset(i_reset), .i_want_trace(want_t),
        .i_want_debug(want_d), .i_jtag(jtag), .i_trig(trig), .o_drv(m_drv), .o_oe(m_oe));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic boot(input logic t, input logic d);
        int hi;
        hi = 0;
        want_t = t;
        want_d = d;
        i_gpio_dir = 32'hffff_ffff;
        i_gpio_out = 32'hffff_ffff;
        i_reset = 1'b1;
        cyc(20);
        chk("oe in reset", o_pin_oe, 16'h0);
        chk("out in reset", o_pin_out, 16'h0);
        chk("gpio_in in reset", o_gpio_in, 32'h0);
        chk("modes in reset", {o_trace_en, o_debug_en, o_cpu_start}, 3'h0);
        i_reset = 1'b0;
        for (int k = 0; k < 5; k++) begin
            cyc(1);
            hi += int'(o_cpu_start === 1'b1);
        end
        chk("start pulses", hi, 1);
        chk("fetch addr", o_fetch_addr, 32'h0);
        chk("trace en", o_trace_en, t);
        chk("debug en", o_debug_en, d);
    endtask
    task automatic sc_gpio;
        i_gpio_dir = 32'hffff_00ff;
        i_gpio_out = 32'ha5c3_ffff;
        cyc(1);
        chk("gpio oe", o_pin_oe, 16'hffff);
        chk("gpio out", o_pin_out, 16'ha5c3);
        i_gpio_dir = 32'h00ff_ffff;
        t_oe = 16'hff00;
        t_val = 16'h5a00;
        cyc(2);
        chk("gpio dir", o_pin_oe, 16'h00ff);
        chk("gpio in", o_gpio_in, 32'h5ac3_0000);
        chk("jtag park", {o_tdi, o_tck, o_tms, o_trst_n}, 4'b1010);
        chk("trigger off", o_external_trigger_in, 1'b0);
        t_oe = 16'h0;
    endtask
    task automatic trace_step(input logic [3:0] p, input logic y, input logic [2:0] q, input logic c);
        i_trace_packet = p;
        i_trace_sync = y;
        i_pipe_state = q;
        i_trace_out_clock = c;
        trig = ~c;
        cyc(1);
        chk("trace oe", o_pin_oe, 16'hfdff);
        chk("trace out", o_pin_out[24:16], {c, q, y, p});
        chk("trigger", o_external_trigger_in, !c);
    endtask
    task automatic sc_trace;
        i_gpio_out = 32'h0;
        trace_step(4'h9, 1'b1, 3'h6, 1'b0);
        trace_step(4'h6, 1'b0, 3'h1, 1'b1);
        trace_step(4'h1, 1'b1, 3'h4, 1'b0);
    endtask
    task automatic sc_debug;
        int tog;
        tog = 0;
        for (int k = 0; k < 24; k++) begin
            i_tdo = k[0];
            jtag = k[3:1];
            cyc(1);
            tog += int'(s[0] != s[1]);
            chk("debug oe", o_pin_oe, 16'h0fff);
            chk("tdo pin", o_pin_out[27], k[0]);
            chk("jtag in", {o_tdi, o_tms, o_trst_n, o_tck}, {jtag[0], jtag[1], jtag[2], s[0]});
            if (k > 3) begin
                chk("returned clock", o_pin_out[26], s[2]);
            end
        end
        chk("tck toggled", tog > 3, 1'b1);
    endtask
    initial begin
        boot(1'b0, 1'b0);
        sc_gpio();
        boot(1'b1, 1'b0);
        sc_trace();
        boot(1'b0, 1'b1);
        sc_debug();
        boot(1'b1, 1'b1);
        chk("both oe", o_pin_oe, 16'h0dff);
        wrap_up();
    end
endmodule // port1_debug_trace_pin_select_tb
